// file: adc_out_defs.svh
// Constants for the converter output port and power mode control
`ifndef ADC_OUT_DEFS_SVH
`define ADC_OUT_DEFS_SVH
`define SAMPLE_WIDTH 10
`define NAP_RECOVERY_CYCLES 100
`define SLEEP_RECOVERY_MS 2
`define CLK_HZ 50000000
`define SLEEP_RECOVERY_CYCLES ((`SLEEP_RECOVERY_MS * `CLK_HZ) / 1000)
`define OFFSET_BINARY_MID 10'h200
`endif

// file: adc_out_pkg.sv
// Types for the converter output port and power mode control
package adc_out_pkg;
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_HIZ,
      MODE_SLEEP,
      MODE_NAP
   } power_mode_type;
endpackage

// file: adc_output_power_mode_ctrl.sv
// Output port tri-state and power mode control of the converter
`timescale 1ns/1ns
`include "adc_out_defs.svh"

// Overview of operation
// RQ1: Output disable high tri-states data and flag
// RQ2: Partner keeps disable static during fast conversion; the model here switches it on every request
// RQ3: Power down select low gives normal operation
// RQ4: Select and disable high: sleep, reference off
// RQ5: Partner ignores samples milliseconds after sleep; the model here waits SLEEP_WAIT cycles, 200 by default
// RQ6: Select high, disable low: nap, reference kept
// RQ7: Partner discards about 100 samples after nap
// RQ8: Sleep and nap tri-state all outputs
// RQ9: Flag high when input exceeds convertible range
// RQ10: Ten bit sample word, bit 9 most significant
// RQ11: Normal enabled mode drives one word per clock
module adc_output_power_mode_ctrl
   import adc_out_pkg::*;
#(
   parameter int SAMPLE_WIDTH = `SAMPLE_WIDTH,
   parameter int NAP_RECOVERY_CYCLES = `NAP_RECOVERY_CYCLES,
   parameter int SLEEP_RECOVERY_CYCLES = `SLEEP_RECOVERY_CYCLES
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Control pins from the receiving logic
   input wire logic i_power_down_select,
   input wire logic i_output_disable_n_hi,
   // Conversion result from the pipeline core
   input wire logic [SAMPLE_WIDTH-1:0] i_core_code,
   input wire logic i_core_over,
   input wire logic i_core_under,
   // Parallel output port, two signals per pin
   output logic [SAMPLE_WIDTH-1:0] o_sample_word,
   output logic [SAMPLE_WIDTH-1:0] o_sample_word_oe,
   output logic o_range_exceeded_flag,
   output logic o_range_exceeded_flag_oe,
   // Power control of the analog core
   output logic o_core_power_on,
   output logic o_reference_on,
   output logic o_data_settled,
   output power_mode_type o_mode
);
   localparam int CNT_W = 24;

   power_mode_type mode_q;
   power_mode_type mode_d;
   logic [SAMPLE_WIDTH-1:0] word_q;
   logic [SAMPLE_WIDTH-1:0] word_d;
   logic flag_q;
   logic flag_d;
   logic drive_q;
   logic drive_d;
   logic load;
   logic [CNT_W-1:0] load_count;
   logic settled;

   // Decodes the two control pins into a power mode
   function automatic power_mode_type decode_mode(input logic sel, input logic dis);
      power_mode_type m;
      m = MODE_NORMAL;
      if (!sel) begin
         m = dis ? MODE_HIZ : MODE_NORMAL; // RQ3
      end else if (dis) begin
         m = MODE_SLEEP; // RQ4
      end else begin
         m = MODE_NAP; // RQ6
      end
      return m;
   endfunction

   // Next mode, word and drive enable
   always_comb begin
      mode_d = decode_mode(i_power_down_select, i_output_disable_n_hi);
      word_d = word_q;
      flag_d = flag_q;
      drive_d = 1'b0;
      case (mode_d)
         MODE_NORMAL: begin
            word_d = i_core_code; // RQ10 RQ11
            flag_d = i_core_over | i_core_under; // RQ9
            drive_d = 1'b1;
         end
         MODE_HIZ: begin
            drive_d = 1'b0; // RQ1
         end
         MODE_SLEEP, MODE_NAP: begin
            drive_d = 1'b0; // RQ8
         end
         default: begin
            drive_d = 1'b0;
         end
      endcase
   end

   // Recovery load on leaving a powered-down mode
   always_comb begin
      load = 1'b0;
      load_count = '0;
      if (mode_q == MODE_SLEEP && mode_d != MODE_SLEEP) begin
         load = 1'b1;
         load_count = CNT_W'(SLEEP_RECOVERY_CYCLES); // RQ5
      end else if (mode_q == MODE_NAP && mode_d != MODE_NAP) begin
         load = 1'b1;
         load_count = CNT_W'(NAP_RECOVERY_CYCLES); // RQ7
      end
   end

   // State registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         mode_q <= MODE_HIZ;
         word_q <= SAMPLE_WIDTH'(`OFFSET_BINARY_MID);
         flag_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         word_q <= word_d;
         flag_q <= flag_d;
         drive_q <= drive_d;
      end
   end

   // Recovery timer, frozen while still powered down
   settle_counter #(
      .WIDTH(CNT_W)
   ) u_settle (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_load(load),
      .i_count(load_count),
      .i_hold(mode_q == MODE_SLEEP || mode_q == MODE_NAP),
      .o_done(settled)
   );

   // Output drive
   assign o_sample_word = word_q;
   assign o_sample_word_oe = {SAMPLE_WIDTH{drive_q}}; // RQ1 RQ8
   assign o_range_exceeded_flag = flag_q;
   assign o_range_exceeded_flag_oe = drive_q; // RQ1
   assign o_core_power_on = (mode_q != MODE_SLEEP) && (mode_q != MODE_NAP); // RQ4 RQ6
   assign o_reference_on = (mode_q != MODE_SLEEP); // RQ4 RQ6
   assign o_data_settled = settled && o_core_power_on; // RQ5 RQ7
   assign o_mode = mode_q;

   // Disable high tri-states the port one clock later; pins seen during reset start nothing
   property p_disable_hiz;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_rst_n && i_output_disable_n_hi |=> (o_sample_word_oe == '0) && !o_range_exceeded_flag_oe;
   endproperty
   a_disable_hiz: assert property (p_disable_hiz) else $error("port driven while disabled"); // RQ1

   property p_normal;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_rst_n && !i_power_down_select && !i_output_disable_n_hi |=> o_mode == MODE_NORMAL && o_range_exceeded_flag_oe;
   endproperty
   a_normal: assert property (p_normal) else $error("normal mode not entered"); // RQ3

   property p_sleep;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_rst_n && i_power_down_select && i_output_disable_n_hi |=> !o_reference_on && !o_core_power_on;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep did not power down"); // RQ4

   property p_nap;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_rst_n && i_power_down_select && !i_output_disable_n_hi |=> o_reference_on && !o_core_power_on;
   endproperty
   a_nap: assert property (p_nap) else $error("nap reference state wrong"); // RQ6

   property p_low_power_hiz;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_mode == MODE_SLEEP || o_mode == MODE_NAP) |-> !o_range_exceeded_flag_oe && o_sample_word_oe == '0;
   endproperty
   a_low_power_hiz: assert property (p_low_power_hiz) else $error("outputs driven in low power"); // RQ8

   property p_flag;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rst_n && !i_power_down_select && !i_output_disable_n_hi) |=>
         o_range_exceeded_flag == $past(i_core_over | i_core_under);
   endproperty
   a_flag: assert property (p_flag) else $error("range flag mismatch"); // RQ9

   property p_word;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rst_n && !i_power_down_select && !i_output_disable_n_hi) |=> o_sample_word == $past(i_core_code);
   endproperty
   a_word: assert property (p_word) else $error("sample word not updated"); // RQ10 RQ11

   property p_nap_recovery;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_mode == MODE_NAP) ##1 (o_mode == MODE_NORMAL) [*8] |-> !o_data_settled;
   endproperty
   a_nap_recovery: assert property (p_nap_recovery) else $error("settled too soon after nap"); // RQ7
endmodule

// file: adc_output_power_mode_ctrl_tb.sv
// Self-checking bench for the converter output and power mode control
`timescale 1ns/1ns
`include "adc_out_defs.svh"
module adc_output_power_mode_ctrl_tb;
   import adc_out_pkg::*;
   typedef struct packed {
      power_mode_type mode;
      logic [9:0] word;
      logic flag;
      logic settled;
   } note_type;
   localparam int SLEEP_CYC = 200;
   int rec_cnt = 0;
   logic settled;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   power_mode_type mode_req = MODE_NORMAL;
   logic pds, odn, usable, flag, flag_oe, core_on, ref_on;
   logic [9:0] code = 10'h000;
   logic over = 1'b0;
   logic under = 1'b0;
   logic [9:0] word, word_oe;
   power_mode_type mode;
   note_type notes[$];
   note_type exp, last;
   int fails = 0;
   int num_checks = 0;
   int used = 0;
   power_mode_type plan[12] = '{MODE_NORMAL, MODE_HIZ, MODE_NORMAL, MODE_NAP, MODE_NORMAL, MODE_SLEEP,
      MODE_HIZ, MODE_NAP, MODE_SLEEP, MODE_NORMAL, MODE_NAP, MODE_HIZ};
   // Clock
   always #10 i_sys_clk = ~i_sys_clk;
   adc_output_power_mode_ctrl #(.SLEEP_RECOVERY_CYCLES(SLEEP_CYC)) dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_power_down_select(pds), .i_output_disable_n_hi(odn), .i_core_code(code), .i_core_over(over),
      .i_core_under(under), .o_sample_word(word), .o_sample_word_oe(word_oe), .o_range_exceeded_flag(flag),
      .o_range_exceeded_flag_oe(flag_oe), .o_core_power_on(core_on), .o_reference_on(ref_on),
      .o_data_settled(settled), .o_mode(mode));
   adc_rx_model #(.SLEEP_WAIT(SLEEP_CYC)) rx_u (.i_sys_clk(i_sys_clk), .i_mode_req(mode_req),
      .o_power_down_select(pds), .o_output_disable_n_hi(odn), .o_data_usable(usable));
   // Compare one value
   task automatic check(input logic [9:0] seen, input logic [9:0] want);
      num_checks++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   // Verdict
   task automatic wrap_up();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One cycle of stimulus and its expected result
   task automatic step(input power_mode_type m, input logic rst_n);
      note_type n;
      logic [9:0] c;
      int r;
      c = 10'($urandom);
      r = $urandom % 4;
      mode_req <= m;
      i_rst_n <= rst_n;
      code <= c;
      over <= (r == 1);
      under <= (r == 2);
      @(posedge i_sys_clk);
      // Recovery count: loaded on leaving sleep or nap, frozen while powered down
      if (!rst_n) rec_cnt = 0;
      else if (last.mode == MODE_SLEEP && m != MODE_SLEEP) rec_cnt = SLEEP_CYC;
      else if (last.mode == MODE_NAP && m != MODE_NAP) rec_cnt = `NAP_RECOVERY_CYCLES;
      else if (last.mode != MODE_SLEEP && last.mode != MODE_NAP && rec_cnt > 0) rec_cnt--;
      if (!rst_n) n = '{MODE_HIZ, 10'h200, 1'b0, 1'b1};
      else if (m == MODE_NORMAL) n = '{m, c, (r == 1) || (r == 2), rec_cnt == 0};
      else n = '{m, last.word, last.flag, (rec_cnt == 0) && (m == MODE_HIZ)};
      last = n;
      notes.push_back(n);
   endtask
   // Output watcher
   always @(posedge i_sys_clk) begin
      #1;
      if (notes.size() > 0) begin
         exp = notes.pop_front();
         check(10'(mode), 10'(exp.mode));
         check(word_oe, {10{exp.mode == MODE_NORMAL}});
         check(10'(flag_oe), 10'(exp.mode == MODE_NORMAL));
         check(word, exp.word);
         check(10'(flag), 10'(exp.flag));
         check(10'(core_on), 10'(exp.mode < MODE_SLEEP));
         check(10'(ref_on), 10'(exp.mode != MODE_SLEEP));
         check(10'(settled), 10'(exp.settled));
         used += usable;
      end
   end
   // Watchdog
   initial begin
      #100000;
      fails++;
      wrap_up();
   end
   // Tests: mode sequence with short stays and a reset in mid-run
   initial begin
      void'($urandom(32'h3453));
      repeat (3) step(MODE_NORMAL, 1'b0);
      foreach (plan[i]) begin
         if (i == 6) repeat (2) step(plan[i], 1'b0);
         repeat ((i % 4 == 3) ? 1 : 220) step(plan[i], 1'b1);
         $display("test %0d mode %0d done, usable %0d", i, plan[i], used);
      end
      #2;
      wrap_up();
   end
endmodule

// file: adc_rx_model.sv
// Receiving logic model that drives the converter control pins
`timescale 1ns/1ns
module adc_rx_model
   import adc_out_pkg::*;
#(
   parameter int SLEEP_WAIT = 200
) (
   // Clock and request
   input wire logic i_sys_clk,
   input wire power_mode_type i_mode_req,
   // Control pins and sample use
   output logic o_power_down_select,
   output logic o_output_disable_n_hi,
   output logic o_data_usable
);
   int wait_q = 0;
   // Pins follow every request directly, including one-cycle requests
   assign o_power_down_select = (i_mode_req == MODE_SLEEP) || (i_mode_req == MODE_NAP);
   assign o_output_disable_n_hi = (i_mode_req == MODE_SLEEP) || (i_mode_req == MODE_HIZ);
   // Samples are ignored while the core recovers
   always @(posedge i_sys_clk) begin
      if (i_mode_req == MODE_SLEEP) wait_q <= SLEEP_WAIT;
      else if (i_mode_req == MODE_NAP) wait_q <= 100;
      else if (wait_q > 0) wait_q <= wait_q - 1;
   end
   assign o_data_usable = (wait_q == 0) && (i_mode_req == MODE_NORMAL);
endmodule

// file: settle_counter.sv
// Down counter that marks output data valid after a recovery period
`timescale 1ns/1ns
module settle_counter #(
   parameter int WIDTH = 24
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_count,
   input wire logic i_hold,
   // Status
   output logic o_done
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   // Next count: reload on a mode exit, count down when not held and not zero
   always_comb begin
      count_d = count_q;
      if (i_load) begin
         count_d = i_count;
      end else if (!i_hold && count_q != '0) begin
         count_d = count_q - 1'b1;
      end
   end

   // Count register
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign o_done = (count_q == '0);
endmodule
